// file: shared/rsf_pkg.sv
`default_nettype none
package rsf_pkg;

   // stream geometry defaults
   localparam int SAMPLE_W_DEF = 24;
   localparam int N_CH_DEF     = 4;
   localparam int WORD_W       = 16;
   localparam int EXP_W_MAX    = 5;    // 5-bit exponent at select code 0
   localparam int GUARD_W      = 16;   // zero bits appended before the rounding shift
   localparam int FRAC_PT      = 4;    // fraction bits kept below the sample lsb for attenuation

   // sample encodings
   localparam logic [1:0] ENC_INT    = 2'h0;
   localparam logic [1:0] ENC_SLICER = 2'h1;
   localparam logic [1:0] ENC_FLOAT  = 2'h2;

   // rounding modes
   localparam logic [2:0] RND_NEAR_EVEN = 3'h0;
   localparam logic [2:0] RND_ZERO      = 3'h1;
   localparam logic [2:0] RND_POS       = 3'h2;
   localparam logic [2:0] RND_NEG       = 3'h3;
   localparam logic [2:0] RND_NEAR_AWAY = 3'h4;

   // embedded slicer bit placements
   localparam logic [2:0] EMB_NONE     = 3'h0;
   localparam logic [2:0] EMB_1_MSB    = 3'h1;
   localparam logic [2:0] EMB_1_LSB    = 3'h2;
   localparam logic [2:0] EMB_2_MSB_S3 = 3'h3;
   localparam logic [2:0] EMB_2_LSB_S3 = 3'h4;
   localparam logic [2:0] EMB_2_MSB_S4 = 3'h5;
   localparam logic [2:0] EMB_2_LSB_S4 = 3'h6;

   // field order
   localparam logic ORDER_S_E_T = 1'b0;
   localparam logic ORDER_S_T_E = 1'b1;

   // pre-conversion attenuation table, in dB, indexed by the setting code
   localparam int ATTEN_DB_STEP = 6;
   localparam int ATTEN_DB [8]  = '{0, -6, -12, -18, 24, 18, 12, 6};

   // reset values of the per-channel configuration
   localparam logic [1:0] RST_ENC      = ENC_INT;
   localparam logic [1:0] RST_EXPW     = 2'h0;
   localparam logic [2:0] RST_RND      = RND_NEAR_EVEN;
   localparam logic       RST_ORDER    = ORDER_S_E_T;
   localparam logic       RST_IMPLICIT = 1'b1;
   localparam logic       RST_NANRES   = 1'b1;
   localparam logic [2:0] RST_ATT      = 3'h0;
   localparam logic [2:0] RST_EMB      = EMB_NONE;

   // buffer depth in words
   localparam logic [1:0] BUF_DEPTH = 2'h2;

endpackage : rsf_pkg
`default_nettype wire

// file: rtl/rsf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
module rsf_formatter #(
   parameter int SAMPLE_W = rsf_pkg::SAMPLE_W_DEF,
   parameter int N_CH     = rsf_pkg::N_CH_DEF,
   parameter int CH_W     = $clog2(N_CH)
) (
   input  wire logic                sys_clk_in,
   input  wire logic                rst_in,
   input  wire logic                cfg_load_in,
   input  wire logic [N_CH-1:0]     channel_enable_mask_in,
   input  wire logic [1:0]          sample_encoding_choice_in,
   input  wire logic [1:0]          exponent_width_select_in,
   input  wire logic [2:0]          rounding_select_in,
   input  wire logic                field_order_select_in,
   input  wire logic                implicit_one_select_in,
   input  wire logic                nan_reserve_select_in,
   input  wire logic [2:0]          pre_conversion_attenuation_in,
   input  wire logic [2:0]          embedded_slicer_bits_select_in,
   input  wire logic [7:0]          external_amp_gain_in,
   input  wire logic                thermal_correction_enable_in,
   input  wire logic                in_valid_in,
   output logic                     in_ready_out,
   input  wire logic [SAMPLE_W-1:0] in_sample_in,
   input  wire logic [CH_W-1:0]     in_channel_in,
   input  wire logic [1:0]          in_slicer_in,
   output logic                     out_valid_out,
   input  wire logic                out_ready_in,
   output logic [15:0]              out_word_out,
   output logic [CH_W-1:0]          out_channel_out
);

   localparam int REF_POS = SAMPLE_W - 1 + rsf_pkg::FRAC_PT;   // bit weight of full scale 1.0

   // per-channel configuration
   logic [1:0] enc_q      [N_CH];
   logic [1:0] expw_q     [N_CH];
   logic [2:0] rnd_q      [N_CH];
   logic       order_q    [N_CH];
   logic       implicit_q [N_CH];
   logic       nanres_q   [N_CH];
   logic [2:0] att_q      [N_CH];
   logic [2:0] emb_q      [N_CH];

   // load only the masked channels; unsupported amp gain and thermal inputs are never read
   for (genvar c = 0; c < N_CH; c++) begin : g_cfg
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
         if (rst_in) begin
            enc_q[c]      <= rsf_pkg::RST_ENC;
            expw_q[c]     <= rsf_pkg::RST_EXPW;
            rnd_q[c]      <= rsf_pkg::RST_RND;
            order_q[c]    <= rsf_pkg::RST_ORDER;
            implicit_q[c] <= rsf_pkg::RST_IMPLICIT;
            nanres_q[c]   <= rsf_pkg::RST_NANRES;
            att_q[c]      <= rsf_pkg::RST_ATT;
            emb_q[c]      <= rsf_pkg::RST_EMB;
         end else if (cfg_load_in && channel_enable_mask_in[c]) begin
            enc_q[c]      <= sample_encoding_choice_in;
            expw_q[c]     <= exponent_width_select_in;
            rnd_q[c]      <= rounding_select_in;
            order_q[c]    <= field_order_select_in;
            implicit_q[c] <= implicit_one_select_in;
            nanres_q[c]   <= nan_reserve_select_in;
            att_q[c]      <= pre_conversion_attenuation_in;
            emb_q[c]      <= embedded_slicer_bits_select_in;
         end
      end
   end

   // float conversion state, visible to the checks below
   int          w_c;
   int          t_c;
   int          bias_c;
   int          emax_c;
   int          ecode_c;
   int          lead_c;
   logic        sgn_c;
   logic        sat_c;
   logic        zero_c;
   logic        implicit_c;
   logic        nanres_c;
   logic [1:0]  enc_c;
   logic [63:0] frac_c;
   logic [15:0] float_word_c;
   logic [15:0] int_word_c;
   logic [15:0] slc_word_c;
   logic [15:0] enc_word_c;

   // per-sample float encoding; exponent follows this sample's own leading one
   always_comb begin
      int          f;
      int          lmin;
      int          leff;
      int          shamt;
      int          sh;
      logic [63:0] mag;
      logic [63:0] xval;
      logic [63:0] big;
      logic [63:0] q;
      logic [63:0] rem;
      logic [63:0] half;
      logic [63:0] word;
      logic        inc;
      logic [SAMPLE_W-1:0] amag;
      f          = 0;
      lmin       = 0;
      leff       = 0;
      shamt      = 0;
      sh         = 0;
      mag        = 64'h0;
      xval       = 64'h0;
      big        = 64'h0;
      q          = 64'h0;
      rem        = 64'h0;
      half       = 64'h0;
      word       = 64'h0;
      inc        = 1'b0;
      amag       = '0;
      implicit_c = implicit_q[in_channel_in];
      nanres_c   = nanres_q[in_channel_in];
      enc_c      = enc_q[in_channel_in];
      w_c        = rsf_pkg::EXP_W_MAX - int'(expw_q[in_channel_in]);
      t_c        = rsf_pkg::WORD_W - 1 - w_c;
      bias_c     = (1 << (w_c - 1)) - 1;
      emax_c     = nanres_c ? (1 << w_c) - 2 : (1 << w_c) - 1;
      f          = implicit_c ? t_c : t_c - 1;
      sgn_c      = in_sample_in[SAMPLE_W-1];
      // negate at sample width, so the widening cannot smear sign bits into the magnitude
      amag       = sgn_c ? -in_sample_in : in_sample_in;
      mag        = 64'(amag);
      // attenuation as whole 6 dB binary steps; positive dB shrinks the value
      sh         = rsf_pkg::FRAC_PT - rsf_pkg::ATTEN_DB[att_q[in_channel_in]] / rsf_pkg::ATTEN_DB_STEP;
      xval       = mag << sh;
      zero_c     = (xval == 64'h0);
      lead_c     = 0;
      for (int i = 0; i < 64; i++) begin
         if (xval[i]) begin
            lead_c = i;
         end
      end
      // below the smallest normal exponent the scale is pinned: subnormal
      lmin  = REF_POS + 1 - bias_c;
      leff  = (lead_c > lmin) ? lead_c : lmin;
      shamt = leff - f + rsf_pkg::GUARD_W;
      big   = xval << rsf_pkg::GUARD_W;
      q     = big >> shamt;
      rem   = big & ((64'h1 << shamt) - 64'h1);
      half  = 64'h1 << (shamt - 1);
      case (rnd_q[in_channel_in])
         rsf_pkg::RND_ZERO:      inc = 1'b0;
         rsf_pkg::RND_POS:       inc = (rem != 64'h0) && !sgn_c;
         rsf_pkg::RND_NEG:       inc = (rem != 64'h0) && sgn_c;
         rsf_pkg::RND_NEAR_AWAY: inc = (rem >= half);
         default:                inc = (rem > half) || ((rem == half) && q[0]);
      endcase
      q = q + 64'(inc);
      // a round-up carry bumps the exponent; a subnormal carry lands on code 1
      if (q >= (64'h1 << (f + 1))) begin
         q       = q >> 1;
         ecode_c = leff - REF_POS + bias_c + 1;
      end else if (q >= (64'h1 << f)) begin
         ecode_c = leff - REF_POS + bias_c;
      end else begin
         ecode_c = 0;
      end
      frac_c = q & ((64'h1 << t_c) - 64'h1);
      // clamp to the largest finite code so a NaN pattern can never leave
      sat_c = (ecode_c > emax_c);
      if (sat_c) begin
         ecode_c = emax_c;
         frac_c  = (64'h1 << t_c) - 64'h1;
      end
      if (order_q[in_channel_in] == rsf_pkg::ORDER_S_T_E) begin
         word = (64'(sgn_c) << 15) | (frac_c << w_c) | 64'(ecode_c);
      end else begin
         word = (64'(sgn_c) << 15) | (64'(ecode_c) << t_c) | frac_c;
      end
      float_word_c = word[15:0];
   end

   // integer and slicer words; the 3-bit slicer variant pads its third bit with zero
   always_comb begin
      int_word_c = in_sample_in[SAMPLE_W-1 -: 16];
      case (emb_q[in_channel_in])
         rsf_pkg::EMB_1_MSB:    slc_word_c = {in_slicer_in[0], int_word_c[15:1]};
         rsf_pkg::EMB_1_LSB:    slc_word_c = {int_word_c[15:1], in_slicer_in[0]};
         rsf_pkg::EMB_2_MSB_S3: slc_word_c = {in_slicer_in, 1'b0, int_word_c[15:3]};
         rsf_pkg::EMB_2_LSB_S3: slc_word_c = {int_word_c[15:3], in_slicer_in, 1'b0};
         rsf_pkg::EMB_2_MSB_S4: slc_word_c = {in_slicer_in, int_word_c[15:2]};
         rsf_pkg::EMB_2_LSB_S4: slc_word_c = {int_word_c[15:2], in_slicer_in};
         default:               slc_word_c = int_word_c;
      endcase
      case (enc_c)
         rsf_pkg::ENC_FLOAT:  enc_word_c = float_word_c;
         rsf_pkg::ENC_SLICER: enc_word_c = slc_word_c;
         default:             enc_word_c = int_word_c;
      endcase
   end

   // two-entry buffer: a stalled receiver holds words here and back-pressures the source
   logic [15:0]     buf_word_q [2];
   logic [CH_W-1:0] buf_ch_q   [2];
   logic            wr_q;
   logic            rd_q;
   logic [1:0]      cnt_q;
   logic            push;
   logic            pop;

   assign in_ready_out    = (cnt_q != rsf_pkg::BUF_DEPTH);
   assign out_valid_out   = (cnt_q != 2'h0);
   assign push            = in_valid_in && in_ready_out;
   assign pop             = out_valid_out && out_ready_in;
   assign out_word_out    = buf_word_q[rd_q];
   assign out_channel_out = buf_ch_q[rd_q];

   // buffer storage, no reset needed on the data path
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         buf_word_q[wr_q] <= enc_word_c;
         buf_ch_q[wr_q]   <= in_channel_in;
      end
   end

   // buffer pointers and fill count
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_q  <= 1'b0;
         rd_q  <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         if (push) begin
            wr_q <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + 2'(push) - 2'(pop);
      end
   end

   // checks
   AST_SIGN_FIRST: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && enc_c == rsf_pkg::ENC_FLOAT |-> enc_word_c[15] == sgn_c)
      else $error("float word sign bit is not in bit 15");
   AST_NAN_RESERVED: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && nanres_c |-> ecode_c != (1 << w_c) - 1)
      else $error("all-ones exponent emitted while reserved");
   AST_EXP_TOP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && !nanres_c && lead_c >= REF_POS + (1 << (w_c - 1)) |-> ecode_c == (1 << w_c) - 1)
      else $error("extended range top exponent not used");
   AST_ZERO_CODE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && zero_c |-> ecode_c == 0 && frac_c == 64'h0)
      else $error("zero sample not encoded as signed zero");
   AST_EXPLICIT_ONE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && !implicit_c && ecode_c != 0 |-> frac_c[t_c-1])
      else $error("explicit leading one missing from significand");
   AST_SATURATE: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && sat_c |-> ecode_c == emax_c && frac_c == (64'h1 << t_c) - 64'h1)
      else $error("overflow not saturated to largest finite code");
   AST_INT_PASS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && enc_c == rsf_pkg::ENC_INT |-> enc_word_c == in_sample_in[SAMPLE_W-1 -: 16])
      else $error("integer encoding altered the sample");
   AST_MASK_HOLD: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      cfg_load_in && !channel_enable_mask_in[0] |=> $stable(enc_q[0]) && $stable(expw_q[0]))
      else $error("unmasked channel configuration changed");
   AST_BUF_STALL: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      out_valid_out && !out_ready_in |=> out_valid_out && $stable(out_word_out))
      else $error("stalled output word not held");
   AST_BUF_FULL: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      push && !pop && cnt_q == 2'h1 |=> !in_ready_out)
      else $error("full buffer still ready");

endmodule : rsf_formatter
`default_nettype wire

// file: tb/rsf_link_sink.sv
`timescale 1ns/1ps
`default_nettype none
// far-side link receiver: takes words on handshake, stalls on request
module rsf_link_sink (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        stall_in,
   input  wire logic        valid_in,
   input  wire logic [15:0] word_in,
   input  wire logic [1:0]  channel_in,
   output logic             ready_out
);
   logic [15:0] word_q [$];
   logic [1:0]  chan_q [$];

   // ready is registered, so a stall lands one edge late, like a real pipelined receiver
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ready_out <= 1'b0;
      end else begin
         ready_out <= !stall_in;
      end
   end

   // one word per handshake edge, kept in arrival order
   always @(posedge clk_in) begin
      if (!rst_in && valid_in && ready_out) begin
         word_q.push_back(word_in);
         chan_q.push_back(channel_in);
      end
   end
endmodule : rsf_link_sink
`default_nettype wire

// file: tb/tb_rsf_formatter.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_rsf_formatter;
   logic        clk = 1'b0, rst = 1'b1, load = 1'b0, vld = 1'b0, stall = 1'b0, therm = 1'b0;
   logic        order = 1'b0, imp = 1'b1, nan = 1'b1, in_rdy, out_vld, out_rdy;
   logic [3:0]  mask = 4'hf;
   logic [1:0]  enc = 2'h2, expw = 2'h0, ch = 2'h0, out_ch, slc = 2'h0;
   logic [2:0]  rnd = 3'h0, att = 3'h0, emb = 3'h0;
   logic [7:0]  gain = 8'h00;
   logic [23:0] smp = 24'h000000;
   logic [15:0] out_w;
   int          n_mismatch = 0, n_checks = 0;
   // expected words: rounding modes 0..4 for +/- (1 - 2^-23), exponent widths for 0.5
   logic [15:0] rnd_p [5] = '{16'h3c00, 16'h3bff, 16'h3c00, 16'h3bff, 16'h3c00};
   logic [15:0] rnd_n [5] = '{16'hbc00, 16'hbbff, 16'hbbff, 16'hbc00, 16'hbc00};
   logic [15:0] exw   [4] = '{16'h3800, 16'h3000, 16'h2000, 16'h1000};

   // slicer placement is loaded with the config, the slicer bits themselves travel with each sample
   rsf_formatter uut (
      .sys_clk_in(clk), .rst_in(rst), .cfg_load_in(load), .channel_enable_mask_in(mask),
      .sample_encoding_choice_in(enc), .exponent_width_select_in(expw), .rounding_select_in(rnd),
      .field_order_select_in(order), .implicit_one_select_in(imp), .nan_reserve_select_in(nan),
      .pre_conversion_attenuation_in(att), .embedded_slicer_bits_select_in(emb),
      .external_amp_gain_in(gain), .thermal_correction_enable_in(therm), .in_valid_in(vld),
      .in_ready_out(in_rdy), .in_sample_in(smp), .in_channel_in(ch), .in_slicer_in(slc),
      .out_valid_out(out_vld), .out_ready_in(out_rdy), .out_word_out(out_w), .out_channel_out(out_ch)
   );

   rsf_link_sink sink (
      .clk_in(clk), .rst_in(rst), .stall_in(stall), .valid_in(out_vld),
      .word_in(out_w), .channel_in(out_ch), .ready_out(out_rdy)
   );

   // 200 MHz
   always #2.5 clk = ~clk;

   task automatic print_verdict;
      if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict

   // one load pulse, then an idle edge so back-to-back loads never retouch load in one step
   task automatic cfg(input logic [3:0] m, input logic [1:0] e, input logic [2:0] a, input logic n);
      mask = m;
      expw = e;
      att = a;
      nan = n;
      load = 1'b1;
      @(negedge clk);
      load = 1'b0;
      @(negedge clk);
   endtask : cfg

   // valid stays up on exit so callers can stream back to back
   task automatic send(input logic [1:0] c, input logic [23:0] s);
      int i;
      ch = c;
      smp = s;
      vld = 1'b1;
      for (i = 0; i < 50 && in_rdy !== 1'b1; i++) @(negedge clk);
      if (i == 50) begin
         n_mismatch++;
         print_verdict();
      end
      @(negedge clk);
   endtask : send

   task automatic get(input logic [1:0] c, input logic [15:0] w);
      int          i;
      logic [15:0] w_seen;
      logic [1:0]  c_seen;
      for (i = 0; i < 50 && sink.word_q.size() == 0; i++) @(negedge clk);
      if (i == 50) begin
         n_mismatch++;
         print_verdict();
      end
      w_seen = sink.word_q.pop_front();
      c_seen = sink.chan_q.pop_front();
      `CHK("out_word", w, w_seen)
      `CHK("out_channel", c, c_seen)
   endtask : get

   task automatic xfer(input logic [1:0] c, input logic [23:0] s, input logic [15:0] w);
      send(c, s);
      vld = 1'b0;
      get(c, w);
   endtask : xfer

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      `CHK("in_ready_rst", 1'b1, in_rdy)
      `CHK("out_valid_rst", 1'b0, out_vld)
      rst = 1'b0;
      @(negedge clk);
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h0, 24'h400000, 16'h3800);
      xfer(2'h1, 24'hc00000, 16'hb800);
      xfer(2'h2, 24'h100000, 16'h3000);
      xfer(2'h3, 24'h000000, 16'h0000);
      gain = 8'h5a;
      therm = 1'b1;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h1, 24'h400000, 16'h3800);
      for (int e = 0; e < 4; e++) begin
         cfg(4'hf, 2'(e), 3'h0, 1'b1);
         xfer(2'h2, 24'h400000, exw[e]);
      end
      // gain of 8 drives 0.5 past the 2-bit range: saturate, or use the spare exponent
      cfg(4'hf, 2'h3, 3'h3, 1'b1);
      xfer(2'h0, 24'h400000, 16'h5fff);
      cfg(4'hf, 2'h3, 3'h3, 1'b0);
      xfer(2'h0, 24'h400000, 16'h6000);
      // the receiver reads code E as 2^(E-bias): one 6 dB step moves the code by one
      for (int a = 0; a < 8; a++) begin
         cfg(4'hf, 2'h0, 3'(a), 1'b1);
         xfer(2'h3, 24'h400000, 16'(14 - rsf_pkg::ATTEN_DB[a] / 6) << 10);
      end
      for (int r = 0; r < 5; r++) begin
         rnd = 3'(r);
         cfg(4'hf, 2'h0, 3'h0, 1'b1);
         xfer(2'h1, 24'h7fffff, rnd_p[r]);
         xfer(2'h1, 24'h800001, rnd_n[r]);
      end
      rnd = rsf_pkg::RND_NEAR_EVEN;
      order = rsf_pkg::ORDER_S_T_E;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h0, 24'h400000, 16'h000e);
      order = rsf_pkg::ORDER_S_E_T;
      imp = 1'b0;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h0, 24'h400000, 16'h3a00);
      imp = 1'b1;
      cfg(4'h1, 2'h0, 3'h0, 1'b1);
      cfg(4'he, 2'h1, 3'h0, 1'b1);
      xfer(2'h0, 24'h400000, 16'h3800);
      xfer(2'h1, 24'h400000, 16'h3000);
      // integer passes the top 16 bits untouched, even with a float attenuation loaded
      enc = rsf_pkg::ENC_INT;
      cfg(4'hf, 2'h0, 3'h3, 1'b1);
      xfer(2'h1, 24'h123456, 16'h1234);
      // slicer bits replace the low bits at the LSB end, or shift the sample down at the MSB end; the 3-bit variant pads with zero
      enc = rsf_pkg::ENC_SLICER;
      emb = rsf_pkg::EMB_1_MSB;
      slc = 2'h1;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h2, 24'h123456, 16'h891a);
      emb = rsf_pkg::EMB_2_MSB_S3;
      slc = 2'h3;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h3, 24'h123456, 16'hc246);
      emb = rsf_pkg::EMB_2_LSB_S4;
      slc = 2'h2;
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      xfer(2'h0, 24'h123456, 16'h1236);
      emb = rsf_pkg::EMB_NONE;
      slc = 2'h0;
      enc = rsf_pkg::ENC_FLOAT;
      // sink held off: two words fill the buffer, the third must wait and none is lost
      cfg(4'hf, 2'h0, 3'h0, 1'b1);
      stall = 1'b1;
      repeat (2) @(negedge clk);
      send(2'h0, 24'h400000);
      send(2'h1, 24'h100000);
      `CHK("in_ready_full", 1'b0, in_rdy)
      `CHK("out_valid_stall", 1'b1, out_vld)
      stall = 1'b0;
      send(2'h2, 24'hc00000);
      vld = 1'b0;
      get(2'h0, 16'h3800);
      get(2'h1, 16'h3000);
      get(2'h2, 16'hb800);
      print_verdict();
   end
endmodule : tb_rsf_formatter
`default_nettype wire
